// ### hw/tas_status.sv
/*
  Terminal adapter status and timing top: status flip-flops, auto step,
  char sync, block, break, dial, hang-up and fill qualification.
  Assumes all inputs synchronous to the selected base clock (clock port).
*/
// How it works
// - Status flip-flops drive processor input lines at instruction end.
// - Read ops set error on cancel, parity, start, stop, overwrite; writes only via abandon-call-retry while dialing.
// - Cancel received during read sets error and repeat together.
// - Abandon-call-retry sets error during dialing write-control.
// - End-of-medium or ringing during dial sets flag.
// - No receive event during transmit sets flag; ringing during dial still does.
// - Fault on lost DSR, carrier, CTS, or I/O while local.
// - While dialing fault ignores carrier and CTS; calling unit power or cable loss instead.
// - Fault preset by init, DSR loss, block, comm fault; cleared on busy preset.
// - Base clock copies medium or high channel clock per rate select.
// - Auto step pair samples transfer request, forming one-clock mode pulse.
// - Timing chain divides base clock by seventeen feeding further division.
// - Bit counter loads seven while load enable low, counts bit clock rises.
// - Decodes: first at nine, seventh at fifteen clock low, eighth at zero.
// - Bit clock is second sync stage gated with chosen low divider tap.
// - Block presets when local at busy preset, ending with fault.
// - Break loads inverse delayed line sample on idle timer expiry.
// - Hang up drives DTR low; modem data mode needs DTR high.
// - Write-control to device one sets dial flip-flop.
// - Phase control gives five start and five midpoint pulses per two divider periods.
// - Char sync samples run then first; first cleared by break and local.
// - Error on overrun; cleared by mode thirteen load, init, mode zero preset.
// - Repeat sits in the fourth status bit.
// - Busy set by processor select, reset only after run-out completes.
`timescale 1ns/1ps
`include "tas_consts.svh"
module tas_status (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Channel clocks and rate switch
  input wire logic channel_medium_clock,
  input wire logic channel_high_clock,
  input wire logic rate_select_high,
  input wire logic rate_switch_level,
  // Processor instruction side
  input wire tas_pkg::tas_op_t op_code,
  input wire logic [3:0] device_number_field,
  input wire logic busy_preset_online,
  input wire logic instruction_end,
  input wire logic op_complete,
  input wire logic mode_transfer_request,
  input wire logic run,
  input wire logic counter_load_enable_n,
  input wire logic receive_mode_thirteen,
  input wire logic idle_mode_zero,
  input wire logic transmitting,
  input wire logic hang_up_request,
  // Receive events
  input wire logic rx_cancel,
  input wire logic rx_end_medium,
  input wire logic rx_parity_error,
  input wire logic rx_no_start,
  input wire logic rx_no_stop,
  input wire logic rx_overwrite,
  // Modem and calling unit
  input wire logic data_set_ready,
  input wire logic carrier,
  input wire logic clear_to_send,
  input wire logic ring_indication,
  input wire logic abandon_call_retry,
  input wire logic caller_power_ok,
  input wire logic comm_fault_preset,
  // Break detection
  input wire logic line_idle_timer_expired,
  input wire logic line_sample_delayed,
  input wire logic local_mode,
  // Status and control outputs
  output logic adapter_base_clock,
  output logic [3:0] processor_input_lines,
  output logic channel_busy,
  output logic block_active,
  output logic break_seen,
  output logic dial_active,
  output logic data_terminal_ready,
  output logic mode_change_pulse,
  output logic fill,
  output logic bit_clock,
  output logic [3:0] bit_count,
  output logic first_data_bit_decode,
  output logic seventh_data_bit_decode,
  output logic eighth_data_bit_decode,
  output logic phase_start_pulse,
  output logic phase_mid_pulse
);
  import tas_pkg::*;

  typedef struct packed {
    logic error;
    logic flag;
    logic fault;
    logic repeat_st;
    logic [3:0] report;
    logic auto_step_first;
    logic auto_step_second;
    logic char_sync_first;
    logic char_sync_second;
    logic block;
    logic brk;
    logic dial;
    logic busy;
    logic dtr;
    logic timer_prev;
  } tas_st_t;

  tas_st_t st_reg, st_next;
  tas_timing_if tim ();
  logic reading;
  logic dialing;
  logic link_lost;

  // Base clock is a plain copy of the chosen channel clock
  assign adapter_base_clock = rate_select_high ? channel_high_clock
    : channel_medium_clock;

  tas_timing u_timing (
    .clock(clock),
    .resetn(resetn),
    .char_sync_second(st_reg.char_sync_second),
    .counter_load_enable_n(counter_load_enable_n),
    .rate_switch_level(rate_switch_level),
    .tim(tim.source)
  );

  // Operation qualifiers
  always_comb begin
    reading = (op_code == TAS_OP_READ) || (op_code == TAS_OP_READ_CTL);
    dialing = st_reg.dial && (op_code == TAS_OP_WRITE_CTL);
    // During dialing clear-to-send is not required
    if (dialing) begin
      link_lost = !data_set_ready || !caller_power_ok;
    end else begin
      link_lost = !data_set_ready || !carrier || !clear_to_send;
    end
  end

  // Status and control next state; sets win over clears, except hang-up clearing DTR
  always_comb begin
    st_next = st_reg;
    // Error clears first so a same-cycle cause wins
    if (receive_mode_thirteen && !counter_load_enable_n) begin
      st_next.error = 1'b0;
    end
    if (idle_mode_zero && busy_preset_online) begin
      st_next.error = 1'b0;
    end
    if (busy_preset_online) begin
      st_next.repeat_st = 1'b0;
      st_next.flag = 1'b0;
    end
    if (reading && !transmitting) begin
      if (rx_parity_error || rx_no_start || rx_no_stop || rx_overwrite) begin
        st_next.error = 1'b1;
      end
      if (rx_cancel) begin
        st_next.error = 1'b1;
        st_next.repeat_st = 1'b1;
      end
      if (rx_end_medium) begin
        st_next.flag = 1'b1;
      end
    end
    if (dialing && abandon_call_retry) begin
      st_next.error = 1'b1;
    end
    // Incoming call wins over the dialing attempt
    if (dialing && ring_indication) begin
      st_next.flag = 1'b1;
      st_next.dial = 1'b0;
    end
    // Fault: clear on busy preset, presets override
    if (busy_preset_online) begin
      st_next.fault = 1'b0;
    end
    st_next.timer_prev = line_idle_timer_expired;
    if (line_idle_timer_expired && !st_reg.timer_prev) begin
      st_next.brk = !line_sample_delayed;
      if (st_reg.busy) begin
        st_next.fault = 1'b1;
      end
    end
    if ((st_reg.busy && link_lost) || (st_reg.busy && st_reg.block) ||
        comm_fault_preset) begin
      st_next.fault = 1'b1;
    end
    // Block sampled as busy is preset
    if (busy_preset_online) begin
      st_next.block = local_mode;
      st_next.busy = 1'b1;
    end else if (st_reg.block && st_reg.busy) begin
      st_next.fault = 1'b1;
    end
    if (op_complete && !busy_preset_online) begin
      st_next.busy = 1'b0;
      st_next.block = 1'b0;
    end
    // Dial set by write-control to device one
    if (busy_preset_online && op_code == TAS_OP_WRITE_CTL &&
        device_number_field == `TAS_DIAL_DEVICE) begin
      st_next.dial = 1'b1;
    end else if (op_complete) begin
      st_next.dial = 1'b0;
    end
    // Hang-up drops DTR and wins; a busy preset without hang-up raises it again
    if (hang_up_request) begin
      st_next.dtr = 1'b0;
    end else if (busy_preset_online) begin
      st_next.dtr = 1'b1;
    end
    // Auto step pair: second clears first, giving a one-clock pulse
    st_next.auto_step_first = mode_transfer_request && !st_reg.auto_step_second;
    st_next.auto_step_second = st_reg.auto_step_first;
    // Char sync: first cleared while break and local both set
    st_next.char_sync_first = run && !(st_reg.brk && local_mode);
    st_next.char_sync_second = st_reg.char_sync_first;
    // Status report latched at instruction end
    if (instruction_end) begin
      st_next.report[`TAS_STAT_ERROR_BIT] = st_reg.error;
      st_next.report[`TAS_STAT_FLAG_BIT] = st_reg.flag;
      st_next.report[`TAS_STAT_FAULT_BIT] = st_reg.fault;
      st_next.report[`TAS_STAT_REPEAT_BIT] = st_reg.repeat_st;
    end
  end

  // State register; fault comes up preset by initialisation
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
      st_reg.fault <= 1'b1;
      st_reg.dtr <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs
  assign processor_input_lines = st_reg.report;
  assign channel_busy = st_reg.busy;
  assign block_active = st_reg.block;
  assign break_seen = st_reg.brk;
  assign dial_active = st_reg.dial;
  assign data_terminal_ready = st_reg.dtr;
  assign mode_change_pulse = st_reg.auto_step_second && !st_reg.auto_step_first;
  // Run-out qualification for write-control instructions
  assign fill = (op_code == TAS_OP_WRITE_CTL) &&
    (st_reg.repeat_st || st_reg.flag || st_reg.fault);
  assign bit_clock = tim.bit_clock;
  assign bit_count = tim.bit_count;
  assign first_data_bit_decode = tim.first_data_bit_decode;
  assign seventh_data_bit_decode = tim.seventh_data_bit_decode;
  assign eighth_data_bit_decode = tim.eighth_data_bit_decode;
  assign phase_start_pulse = tim.start_pulse;
  assign phase_mid_pulse = tim.mid_pulse;
endmodule // tas_status

// ### common/tas_consts.svh
/*
  Timing and field constants for the terminal adapter status and timing block.
  Assumes inclusion by bare name from files under hw/ and common/.
*/
`ifndef TAS_CONSTS_SVH
`define TAS_CONSTS_SVH
`define TAS_BIT_LOAD_VALUE 4'h7
`define TAS_BIT_FIRST_DATA 4'h9
`define TAS_BIT_SEVENTH_DATA 4'hF
`define TAS_BIT_EIGHTH_DATA 4'h0
`define TAS_DIV_TERMINAL 5'h10
`define TAS_DIV_WIDTH 5
`define TAS_LOW_WIDTH 5
`define TAS_PHASE_PULSES 3'h5
`define TAS_PHASE_WIDTH 4
`define TAS_PHASE_MID_START 4'h8
`define TAS_DIAL_DEVICE 4'h1
`define TAS_STAT_ERROR_BIT 0
`define TAS_STAT_FLAG_BIT 1
`define TAS_STAT_FAULT_BIT 2
`define TAS_STAT_REPEAT_BIT 3
`endif

// ### common/tas_pkg.sv
/*
  Types shared by the terminal adapter status and timing design.
  Assumes tas_consts.svh is available on the include path.
*/
package tas_pkg;
  typedef enum logic [3:0] {
    TAS_OP_READ = 4'h1,
    TAS_OP_READ_CTL = 4'h2,
    TAS_OP_WRITE = 4'h4,
    TAS_OP_WRITE_CTL = 4'h8
  } tas_op_t;
  typedef logic [3:0] tas_status_t;
endpackage

// ### common/tas_timing_if.sv
/*
  Interface carrying the bit-timing signals from the timing module to the top.
  Assumes a single base clock domain.
*/
`timescale 1ns/1ps
interface tas_timing_if;
  logic bit_clock;
  logic [3:0] bit_count;
  logic first_data_bit_decode;
  logic seventh_data_bit_decode;
  logic eighth_data_bit_decode;
  logic start_pulse;
  logic mid_pulse;
  logic divider_high_stage;
  modport source (output bit_clock, bit_count, first_data_bit_decode,
    seventh_data_bit_decode, eighth_data_bit_decode, start_pulse, mid_pulse,
    divider_high_stage);
  modport sink (input bit_clock, bit_count, first_data_bit_decode,
    seventh_data_bit_decode, eighth_data_bit_decode, start_pulse, mid_pulse,
    divider_high_stage);
endinterface

// ### hw/tas_timing.sv
/*
  Bit-timing chain: divide-by-seventeen, low-rate divider, bit counter,
  data-bit decodes and phase pulse bursts.
  Assumes the caller supplies the char sync level and counter load enable.
*/
`timescale 1ns/1ps
`include "tas_consts.svh"
module tas_timing (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Control
  input wire logic char_sync_second,
  input wire logic counter_load_enable_n,
  input wire logic rate_switch_level,
  // Timing outputs
  tas_timing_if.source tim
);
  import tas_pkg::*;

  typedef struct packed {
    logic [`TAS_DIV_WIDTH-1:0] high_div;
    logic divider_high_stage;
    logic [`TAS_LOW_WIDTH-1:0] low_rate_divider;
    logic bit_clock;
    logic [3:0] bit_count;
    logic phase_toggle;
    logic phase_toggle_delayed;
    logic [`TAS_PHASE_WIDTH-1:0] phase_count;
    logic start_pulse;
    logic mid_pulse;
  } tas_tim_state_t;

  tas_tim_state_t st_reg, st_next;
  logic tap;

  // Next-state logic for the whole chain
  always_comb begin
    st_next = st_reg;
    // Terminal decode closes the count: states 0 to 16 give seventeen clocks
    st_next.divider_high_stage = (st_reg.high_div == `TAS_DIV_TERMINAL - 5'h01);
    if (st_reg.divider_high_stage) begin
      st_next.high_div = '0;
      st_next.low_rate_divider = st_reg.low_rate_divider + 5'h01;
    end else begin
      st_next.high_div = st_reg.high_div + 5'h01;
    end
    // Tap picked by rate switch; gated by second sync stage
    tap = rate_switch_level ? st_reg.low_rate_divider[4] : st_reg.low_rate_divider[3];
    st_next.bit_clock = char_sync_second & tap;
    if (!counter_load_enable_n) begin
      st_next.bit_count = `TAS_BIT_LOAD_VALUE;
    end else if (st_next.bit_clock && !st_reg.bit_clock) begin
      st_next.bit_count = st_reg.bit_count + 4'h1;
    end
    // Half-rate toggle and its delayed copy drive the phase counter
    st_next.phase_toggle = ~st_reg.phase_toggle;
    st_next.phase_toggle_delayed = st_reg.phase_toggle;
    // Restart every second divider period; saturate so the dead time cannot wrap
    if (st_reg.divider_high_stage && st_reg.low_rate_divider[0]) begin
      st_next.phase_count = '0;
    end else if (st_reg.phase_toggle && !st_reg.phase_toggle_delayed &&
        st_reg.phase_count != 4'hF) begin
      st_next.phase_count = st_reg.phase_count + 4'h1;
    end
    // Five pulses near start, dead time, five near midpoint
    st_next.start_pulse = st_reg.phase_toggle && !st_reg.phase_toggle_delayed &&
      (st_reg.phase_count < 4'(`TAS_PHASE_PULSES));
    st_next.mid_pulse = st_reg.phase_toggle && !st_reg.phase_toggle_delayed &&
      (st_reg.phase_count >= `TAS_PHASE_MID_START) &&
      (st_reg.phase_count < `TAS_PHASE_MID_START + 4'(`TAS_PHASE_PULSES));
  end

  // State register, idle after initialisation
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tim.bit_clock = st_reg.bit_clock;
  assign tim.bit_count = st_reg.bit_count;
  assign tim.divider_high_stage = st_reg.divider_high_stage;
  assign tim.start_pulse = st_reg.start_pulse;
  assign tim.mid_pulse = st_reg.mid_pulse;
  // Bit-position decodes
  assign tim.first_data_bit_decode = (st_reg.bit_count == `TAS_BIT_FIRST_DATA);
  assign tim.seventh_data_bit_decode = (st_reg.bit_count == `TAS_BIT_SEVENTH_DATA) &&
    !st_reg.bit_clock;
  assign tim.eighth_data_bit_decode = (st_reg.bit_count == `TAS_BIT_EIGHTH_DATA);
endmodule // tas_timing

// ### test/tas_chk.sv
/*
  Concurrent checks on the terminal adapter status and timing top.
  Assumes binding to tas_status and sight of its ports only.
*/
`timescale 1ns/1ps
module tas_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Processor and line inputs
  input wire tas_pkg::tas_op_t op_code,
  input wire logic [3:0] device_number_field,
  input wire logic busy_preset_online,
  input wire logic instruction_end,
  input wire logic mode_transfer_request,
  input wire logic counter_load_enable_n,
  input wire logic transmitting,
  input wire logic rx_cancel,
  input wire logic ring_indication,
  input wire logic local_mode,
  // Outputs watched
  input wire logic [3:0] processor_input_lines,
  input wire logic dial_active,
  input wire logic block_active,
  input wire logic mode_change_pulse,
  input wire logic bit_clock,
  input wire logic [3:0] bit_count,
  input wire logic first_data_bit_decode,
  input wire logic seventh_data_bit_decode,
  input wire logic eighth_data_bit_decode
);
  import tas_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // Report lines only move after an instruction end
  a_report_held: assert property (
    !$past(instruction_end) |-> $stable(processor_input_lines))
    else $error("status lines moved without instruction end");
  // Cancel marks error and repeat in the same report
  a_cancel_both_set: assert property (
    (rx_cancel && op_code == TAS_OP_READ && !transmitting) ##1 instruction_end
    |=> processor_input_lines[0] && processor_input_lines[3])
    else $error("cancel did not report error and repeat");
  // Incoming ring while dialling is flagged
  a_ring_sets_flag: assert property (
    (dial_active && ring_indication) ##1 instruction_end |=> processor_input_lines[1])
    else $error("ring during dial not flagged");
  // Write control to device one starts dialling
  a_dial_on_wrc: assert property (
    busy_preset_online && op_code == TAS_OP_WRITE_CTL && device_number_field == 4'h1
    && !local_mode && !ring_indication |=> dial_active)
    else $error("dial not started");
  // Local at busy preset blocks the operation
  a_block_on_local: assert property (
    busy_preset_online && local_mode |=> block_active)
    else $error("block not set while local");
  // Counter held at seven under load
  a_load_seven: assert property (
    !counter_load_enable_n |=> bit_count == 4'h7)
    else $error("bit counter not loaded with seven");
  // Bit position decodes track the counter
  a_decode_map: assert property (
    first_data_bit_decode == (bit_count == 4'h9) && eighth_data_bit_decode == (bit_count == 4'h0)
    && seventh_data_bit_decode == (bit_count == 4'hF && !bit_clock))
    else $error("bit decode mismatch");
  // Mode step follows a request quickly
  a_mode_step_soon: assert property (
    $rose(mode_transfer_request) |-> ##[1:2] mode_change_pulse)
    else $error("mode change pulse missing");
  // Mode step lasts one clock only
  a_mode_step_single: assert property (
    mode_change_pulse |=> !mode_change_pulse)
    else $error("mode change pulse too long");
  c_dial_ring: cover property (dial_active && ring_indication);
  c_block: cover property (block_active);
  c_first_bit: cover property (first_data_bit_decode);
endmodule // tas_chk
bind tas_status tas_chk u_chk (.clock, .resetn, .op_code, .device_number_field,
  .busy_preset_online, .instruction_end, .mode_transfer_request, .counter_load_enable_n,
  .transmitting, .rx_cancel, .ring_indication, .local_mode, .processor_input_lines,
  .dial_active, .block_active, .mode_change_pulse, .bit_clock, .bit_count,
  .first_data_bit_decode, .seventh_data_bit_decode, .eighth_data_bit_decode);

// ### test/tas_modem.sv
/*
  Modem and calling unit model at the adapter's far side.
  Assumes the bench drives its scenario controls at the rising clock edge.
*/
`timescale 1ns/1ps
module tas_modem (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Adapter and scenario controls
  input wire logic data_terminal_ready,
  input wire logic line_drop,
  input wire logic call_in,
  input wire logic call_abandon,
  // Modem and calling unit lines
  output logic data_set_ready,
  output logic carrier,
  output logic clear_to_send,
  output logic ring_indication,
  output logic abandon_call_retry,
  output logic caller_power_ok
);
  // Data mode only while terminal ready holds; a hang-up drops it next clock
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      {data_set_ready, carrier, clear_to_send} <= 3'h0;
      {ring_indication, abandon_call_retry, caller_power_ok} <= 3'h0;
    end else begin
      {data_set_ready, carrier, clear_to_send} <= {3{data_terminal_ready & ~line_drop}};
      ring_indication <= call_in & data_terminal_ready;
      abandon_call_retry <= call_abandon;
      caller_power_ok <= 1'b1;
    end
  end
endmodule // tas_modem

// ### test/tas_tb.sv
/*
  Self-checking bench for the adapter status and timing top.
  Assumes tas_modem as far side and tas_chk bound to the top.
*/
`timescale 1ns/1ps
module tb;
  import tas_pkg::*;
  logic clock = 0, resetn = 0, channel_medium_clock = 0, channel_high_clock = 1;
  logic rate_select_high = 0, rate_switch_level = 1, busy_preset_online = 0;
  logic instruction_end = 0, op_complete = 0, mode_transfer_request = 0, run = 0;
  logic counter_load_enable_n = 1, receive_mode_thirteen = 0, idle_mode_zero = 1;
  logic transmitting = 0, hang_up_request = 0, rx_cancel = 0, rx_end_medium = 0;
  logic rx_parity_error = 0, rx_no_start = 0, rx_no_stop = 0, rx_overwrite = 0;
  logic comm_fault_preset = 0, line_idle_timer_expired = 0, line_sample_delayed = 1;
  logic local_mode = 0, line_drop = 0, call_in = 0, call_abandon = 0;
  tas_op_t op_code = TAS_OP_READ;
  logic [3:0] device_number_field = 4'h0;
  logic data_set_ready, carrier, clear_to_send, ring_indication, abandon_call_retry;
  logic caller_power_ok, adapter_base_clock, channel_busy, block_active, break_seen;
  logic dial_active, data_terminal_ready, mode_change_pulse, fill, bit_clock;
  logic first_data_bit_decode, seventh_data_bit_decode, eighth_data_bit_decode;
  logic phase_start_pulse, phase_mid_pulse;
  logic [3:0] processor_input_lines, bit_count;
  logic [3:0] rd_exp [6] = '{4'h9, 4'h2, 4'h1, 4'h1, 4'h1, 4'h1};
  int n_fail = 0, compares = 0;
  tas_status dut (.clock, .resetn, .channel_medium_clock, .channel_high_clock,
    .rate_select_high, .rate_switch_level, .op_code, .device_number_field,
    .busy_preset_online, .instruction_end, .op_complete, .mode_transfer_request, .run,
    .counter_load_enable_n, .receive_mode_thirteen, .idle_mode_zero, .transmitting,
    .hang_up_request, .rx_cancel, .rx_end_medium, .rx_parity_error, .rx_no_start,
    .rx_no_stop, .rx_overwrite, .data_set_ready, .carrier, .clear_to_send,
    .ring_indication, .abandon_call_retry, .caller_power_ok, .comm_fault_preset,
    .line_idle_timer_expired, .line_sample_delayed, .local_mode, .adapter_base_clock,
    .processor_input_lines, .channel_busy, .block_active, .break_seen, .dial_active,
    .data_terminal_ready, .mode_change_pulse, .fill, .bit_clock, .bit_count,
    .first_data_bit_decode, .seventh_data_bit_decode, .eighth_data_bit_decode,
    .phase_start_pulse, .phase_mid_pulse);
  tas_modem u_modem (.clock, .resetn, .data_terminal_ready, .line_drop, .call_in,
    .call_abandon, .data_set_ready, .carrier, .clear_to_send, .ring_indication,
    .abandon_call_retry, .caller_power_ok);
  // Base clock, 8 ns period
  initial forever #4 clock = ~clock;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task test_done;
    if (n_fail == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Bounded wait for a bit position, optionally with the bit clock low
  task wait_bits(input logic [3:0] v, input logic lo);
    int n;
    for (n = 0; n < 8000 && !(bit_count === v && (!lo || bit_clock === 1'b0)); n++)
      @(posedge clock) #1;
    if (n == 8000) begin
      n_fail++;
      test_done;
    end
  endtask
  // Processor presets busy with an op; busy preset also clears old status
  task op(input tas_op_t o, input logic [3:0] d);
    @(posedge clock) busy_preset_online <= 1'b1;
    op_code <= o;
    device_number_field <= d;
    @(posedge clock) busy_preset_online <= 1'b0;
  endtask
  // Called on an edge; instruction end then read the report
  task rep(input logic [3:0] exp);
    instruction_end <= 1'b1;
    @(posedge clock) instruction_end <= 1'b0;
    #1 chk(processor_input_lines, exp);
  endtask
  // Every receive event under one op kind
  task t_rx(input tas_op_t o, input logic tx);
    for (int ev = 0; ev < 6; ev++) begin
      op(o, 4'h0);
      transmitting <= tx;
      @(posedge clock) {rx_overwrite, rx_no_stop, rx_no_start, rx_parity_error,
        rx_end_medium, rx_cancel} <= 6'h01 << ev;
      @(posedge clock) {rx_overwrite, rx_no_stop, rx_no_start, rx_parity_error,
        rx_end_medium, rx_cancel} <= 6'h00;
      rep(o == TAS_OP_WRITE ? 4'h0 : rd_exp[ev]);
    end
    @(posedge clock) transmitting <= 1'b0;
  endtask
  // Dial then ring or abandon from the calling unit
  task t_dial(input logic abandon);
    op(TAS_OP_WRITE_CTL, 4'h1);
    #1 chk(dial_active, 1'b1);
    @(posedge clock) {call_abandon, call_in} <= {abandon, ~abandon};
    @(posedge clock);
    @(posedge clock) {call_abandon, call_in} <= 2'h0;
    rep(abandon ? 4'h1 : 4'h2);
    #1 chk(dial_active, abandon);
    chk(fill, !abandon);
  endtask
  // Modem drop or fault preset while busy
  task t_fault(input logic k);
    op(TAS_OP_READ, 4'h0);
    @(posedge clock) {comm_fault_preset, line_drop} <= {k, ~k};
    @(posedge clock);
    @(posedge clock) {comm_fault_preset, line_drop} <= 2'h0;
    rep(4'h4);
    repeat (3) @(posedge clock);
  endtask
  initial begin
    int i;
    int k;
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    #1 chk(processor_input_lines, 4'h0);
    chk(data_terminal_ready, 1'b1);
    for (i = 0; i < 2; i++) begin
      @(posedge clock) rate_select_high <= i[0];
      @(posedge clock) #1 chk(adapter_base_clock, i[0]);
    end
    t_rx(TAS_OP_READ, 1'b0);
    t_rx(TAS_OP_READ_CTL, 1'b0);
    t_rx(TAS_OP_WRITE, 1'b1);
    t_dial(1'b0);
    t_dial(1'b1);
    t_fault(1'b0);
    t_fault(1'b1);
    for (i = 0; i < 2; i++) begin
      @(posedge clock) line_sample_delayed <= i[0];
      @(posedge clock) line_idle_timer_expired <= 1'b1;
      @(posedge clock) line_idle_timer_expired <= 1'b0;
      #1 chk(break_seen, !i[0]);
    end
    @(posedge clock) local_mode <= 1'b1;
    op(TAS_OP_WRITE, 4'h0);
    #1 chk(block_active, 1'b1);
    // Fault follows block one clock later, so end the instruction after it
    @(posedge clock);
    rep(4'h4);
    @(posedge clock) {local_mode, op_complete} <= 2'h1;
    @(posedge clock) op_complete <= 1'b0;
    #1 chk(channel_busy, 1'b0);
    @(posedge clock) mode_transfer_request <= 1'b1;
    @(posedge clock) mode_transfer_request <= 1'b0;
    k = 0;
    repeat (6) @(posedge clock) #1 if (mode_change_pulse === 1'b1) k++;
    chk(k[7:0], 8'h01);
    // Two burst periods: five start and five midpoint pulses in each
    k = 0;
    i = 0;
    repeat (68) @(posedge clock) #1 begin
      k += phase_start_pulse;
      i += phase_mid_pulse;
    end
    chk(k[7:0], 8'h0A);
    chk(i[7:0], 8'h0A);
    @(posedge clock) hang_up_request <= 1'b1;
    repeat (3) @(posedge clock);
    #1 chk(data_terminal_ready, 1'b0);
    chk(data_set_ready, 1'b0);
    @(posedge clock) hang_up_request <= 1'b0;
    op(TAS_OP_WRITE, 4'h0);
    #1 chk(data_terminal_ready, 1'b1);
    @(posedge clock) counter_load_enable_n <= 1'b0;
    repeat (3) @(posedge clock);
    #1 chk(bit_count, 4'h7);
    @(posedge clock) {counter_load_enable_n, run} <= 2'h3;
    wait_bits(4'h9, 1'b0);
    chk(first_data_bit_decode, 1'b1);
    wait_bits(4'hF, 1'b1);
    chk(seventh_data_bit_decode, 1'b1);
    wait_bits(4'h0, 1'b0);
    chk(eighth_data_bit_decode, 1'b1);
    test_done;
  end
endmodule // tb
